// *** shared/scs_cfg.svh ***
// constants for the configuration strap sampler
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
// register offsets
`define SCS_ADDR_CTRL    4'h0
`define SCS_ADDR_STRAPS  4'h1
`define SCS_ADDR_STATUS  4'h2
// control register fields
`define SCS_CTRL_SFT_PD   0
`define SCS_CTRL_ADV_MST  1
`define SCS_CTRL_FORCED_MASTER_CFG  2
`define SCS_CTRL_TX_HI    3
`define SCS_CTRL_AN_EN    4
`define SCS_CTRL_SW_RST   5
// reset value of the autoneg enable bit
`define SCS_AN_EN_RST     1'b1
// cycles the pins settle in strap mode after a reset event, before the latch cycle
`define SCS_SETTLE_CYC    4'h4
`endif

// *** shared/scs_pkg.sv ***
// types shared by the configuration strap sampler
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_MAC_RMII  = 2'b00,
        SCS_MAC_RGMII = 2'b01,
        SCS_MAC_RSVD  = 2'b10,
        SCS_MAC_MII   = 2'b11
    } scs_mac_e;
    typedef enum logic [1:0] {
        SCS_ST_SETTLE = 2'b00,
        SCS_ST_LATCH  = 2'b01,
        SCS_ST_RUN    = 2'b10
    } scs_state_e;
endpackage

// *** core/scs_strap_reg.sv ***
// strap capture register: loads only on the latch pulse
`timescale 1ns/1ps
`include "scs_cfg.svh"
module scs_strap_reg
    import scs_pkg::*;
#(
    parameter int W = 10
)
(
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         load,
    input  wire logic [W-1:0] pins,
    output logic      [W-1:0] value_r
);
    logic [W-1:0] value_nxt; // next held value

    // hold except on the single latch pulse, so later pin activity is ignored
    always_comb
    begin
        value_nxt = value_r;
        if (load)
        begin
            value_nxt = pins;
        end
    end

    // reset value equals pulled-down pins
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            value_r <= '0;
        end
        else
        begin
            value_r <= value_nxt;
        end
    end
endmodule

// *** core/scs_sampler.sv ***
// configuration strap sampler with register port
`timescale 1ns/1ps
`include "scs_cfg.svh"
module scs_sampler
    import scs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // shared pins as seen at the pads
    input  wire logic        media_conv_strap,
    input  wire logic        phy_addr_strap_bit0,
    input  wire logic        phy_addr_strap_bit1,
    input  wire logic        phy_addr_strap_bit2,
    input  wire logic        powerdown_after_reset_strap,
    input  wire logic        master_pref_strap,
    input  wire logic        tx_level_strap,
    input  wire logic        mac_if_strap_lo,
    input  wire logic        mac_if_strap_hi,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata_r,
    // configuration outputs
    output logic             pins_released_r,
    output logic [2:0]       phy_addr_r,
    output logic [1:0]       mac_if_sel_r,
    output logic             media_conv_en_r,
    output logic             soft_powerdown_ctl_r,
    output logic             adv_master_pref_r,
    output logic             forced_master_cfg_r,
    output logic             high_tx_level_ability_r,
    output logic             modules_off_r,
    output logic             autoneg_start_r
);
    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    scs_state_e  st_r, st_nxt;        // sampling state
    logic [3:0]  cnt_r, cnt_nxt;      // settle counter
    logic        sw_rst_r, sw_rst_nxt; // software reset request
    logic        latch;               // one-cycle strap latch pulse
    logic [9:0]  straps;              // pins gathered for capture
    logic [9:0]  held;                // latched strap image

    // a reset event (hardware or software) restarts sampling
    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            SCS_ST_SETTLE:
            begin
                // pins still in strap mode while pulls settle
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == `SCS_SETTLE_CYC - 4'h1)
                begin
                    st_nxt = SCS_ST_LATCH;
                end
            end
            SCS_ST_LATCH:
            begin
                st_nxt = SCS_ST_RUN;
            end
            SCS_ST_RUN:
            begin
                if (sw_rst_r)
                begin
                    st_nxt  = SCS_ST_SETTLE;
                    cnt_nxt = 4'h0;
                end
            end
            default:
            begin
                st_nxt = SCS_ST_SETTLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            st_r  <= SCS_ST_SETTLE;
            cnt_r <= 4'h0;
        end
        else
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign latch  = (st_r == SCS_ST_LATCH);
    assign straps = {media_conv_strap, mac_if_strap_hi, mac_if_strap_lo, tx_level_strap,
                     master_pref_strap, powerdown_after_reset_strap,
                     phy_addr_strap_bit2, phy_addr_strap_bit1, phy_addr_strap_bit0, 1'b0};

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    scs_strap_reg #(.W(10)) u_cap (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .load    (latch),
        .pins    (straps),
        .value_r (held)
    );

    // ------------------------------------------------------------
    // control bits and register port
    // ------------------------------------------------------------
    logic sft_pd_nxt, adv_nxt, cfg_nxt, txhi_nxt, an_en_r, an_en_nxt;
    logic rel_nxt, off_nxt, ans_nxt;
    logic [15:0] rd_nxt;
    logic        wr_ctrl;

    assign wr_ctrl = reg_wr && (reg_addr == `SCS_ADDR_CTRL) && (st_r == SCS_ST_RUN);

    always_comb
    begin
        sft_pd_nxt = soft_powerdown_ctl_r;
        adv_nxt    = adv_master_pref_r;
        cfg_nxt    = forced_master_cfg_r;
        txhi_nxt   = high_tx_level_ability_r;
        an_en_nxt  = an_en_r;
        sw_rst_nxt = 1'b0;
        if (latch)
        begin
            // defaults reload from straps at every reset event
            // strap image: bit4 power-down, bit5 master preference, bit6 tx level
            sft_pd_nxt = ~straps[4];
            adv_nxt    = straps[5];
            cfg_nxt    = straps[5];
            txhi_nxt   = ~straps[6];
        end
        else if (wr_ctrl)
        begin
            sft_pd_nxt = reg_wdata[`SCS_CTRL_SFT_PD];
            adv_nxt    = reg_wdata[`SCS_CTRL_ADV_MST];
            cfg_nxt    = reg_wdata[`SCS_CTRL_FORCED_MASTER_CFG];
            an_en_nxt  = reg_wdata[`SCS_CTRL_AN_EN];
            sw_rst_nxt = reg_wdata[`SCS_CTRL_SW_RST];
            // ability is writable only while the tx strap is low; a high strap locks it at zero
            if (!held[6])
            begin
                txhi_nxt = reg_wdata[`SCS_CTRL_TX_HI];
            end
        end
        rel_nxt = (st_nxt == SCS_ST_RUN);
        off_nxt = sft_pd_nxt;
        // autoneg starts in the same cycle as release when enabled and not powered down
        ans_nxt = latch && an_en_nxt && !sft_pd_nxt;
        rd_nxt  = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `SCS_ADDR_CTRL:
                begin
                    rd_nxt = {10'h000, 1'b0, an_en_r, high_tx_level_ability_r, forced_master_cfg_r,
                              adv_master_pref_r, soft_powerdown_ctl_r};
                end
                `SCS_ADDR_STRAPS:
                begin
                    rd_nxt = {6'h00, held};
                end
                `SCS_ADDR_STATUS:
                begin
                    rd_nxt = {13'h0000, modules_off_r, pins_released_r, st_r == SCS_ST_RUN};
                end
                default:
                begin
                    rd_nxt = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            soft_powerdown_ctl_r    <= 1'b1;
            adv_master_pref_r       <= 1'b0;
            forced_master_cfg_r     <= 1'b0;
            high_tx_level_ability_r <= 1'b1;
            an_en_r                 <= `SCS_AN_EN_RST;
            sw_rst_r                <= 1'b0;
            pins_released_r         <= 1'b0;
            modules_off_r           <= 1'b1;
            autoneg_start_r         <= 1'b0;
            reg_rdata_r             <= 16'h0000;
        end
        else
        begin
            soft_powerdown_ctl_r    <= sft_pd_nxt;
            adv_master_pref_r       <= adv_nxt;
            forced_master_cfg_r     <= cfg_nxt;
            high_tx_level_ability_r <= txhi_nxt;
            an_en_r                 <= an_en_nxt;
            sw_rst_r                <= sw_rst_nxt;
            pins_released_r         <= rel_nxt;
            modules_off_r           <= off_nxt;
            autoneg_start_r         <= ans_nxt;
            reg_rdata_r             <= rd_nxt;
        end
    end

    // ------------------------------------------------------------
    // decoded strap outputs
    // ------------------------------------------------------------
    logic [2:0] addr_nxt;
    logic [1:0] mac_nxt;
    logic       mc_nxt;
    always_comb
    begin
        addr_nxt = latch ? straps[3:1] : phy_addr_r;
        mac_nxt  = latch ? straps[8:7] : mac_if_sel_r;
        // converter only meaningful in rmii mode
        mc_nxt   = latch ? (straps[9] && straps[8:7] == SCS_MAC_RMII) : media_conv_en_r;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            phy_addr_r      <= 3'h0;
            mac_if_sel_r    <= SCS_MAC_RMII;
            media_conv_en_r <= 1'b0;
        end
        else
        begin
            phy_addr_r      <= addr_nxt;
            mac_if_sel_r    <= mac_nxt;
            media_conv_en_r <= mc_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_latch;
        st_r == SCS_ST_LATCH;
    endsequence

    chk_addr_latch: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_latch |=> phy_addr_r == $past(straps[3:1])) else $error("address not latched");
    chk_pd_strap: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_latch |=> soft_powerdown_ctl_r == !$past(powerdown_after_reset_strap))
        else $error("power-down default wrong");
    chk_master_def: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_latch |=> adv_master_pref_r == $past(master_pref_strap) && forced_master_cfg_r == adv_master_pref_r)
        else $error("master default wrong");
    chk_tx_lock: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (held[6] && st_r == SCS_ST_RUN) |=> !high_tx_level_ability_r) else $error("tx ability unlocked");
    chk_tx_def: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_latch |=> high_tx_level_ability_r == !$past(tx_level_strap)) else $error("tx ability default");
    chk_addr_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_r == SCS_ST_RUN && !sw_rst_r) |=> $stable(phy_addr_r) && $stable(mac_if_sel_r))
        else $error("latched value moved");
    chk_pd_exit: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (soft_powerdown_ctl_r && !latch && !(wr_ctrl && !reg_wdata[0])) |=> soft_powerdown_ctl_r)
        else $error("left power-down without write");
    chk_an_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
        autoneg_start_r |-> !soft_powerdown_ctl_r && an_en_r && $past(latch)) else $error("bad autoneg start");
    chk_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_latch |=> pins_released_r ##1 pins_released_r) else $error("pins not released");
endmodule

// *** testbench/scs_strap_src.sv ***
// strap source model: host gpio levels over the internal pull-downs
`timescale 1ns/1ps
module scs_strap_src
(
    input  wire logic [8:0] level,
    input  wire logic [8:0] drive_en,
    output logic      [8:0] pin
);
    // an undriven strap reads low through its pull-down, never the last level
    assign pin = level & drive_en;
endmodule

// *** testbench/scs_sampler_tb.sv ***
// self-checking bench for the strap sampler
`timescale 1ns/1ps
`include "scs_cfg.svh"
module scs_sampler_tb;
    import scs_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic [8:0]  lvl     = 9'h000; // gpio levels, bit order a0 a1 a2 pd ms tx mlo mhi media
    logic [8:0]  den     = 9'h000; // gpio drive enables
    logic [8:0]  pin;
    logic [3:0]  reg_addr  = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr  = 1'b0;
    logic        reg_rd  = 1'b0;
    logic        rd_d    = 1'b0; // read data stand one cycle after the strobe
    logic [15:0] reg_rdata_r;
    logic        rel, media, spd, off, adv, fm, hi, an;
    logic [2:0]  pa;
    logic [1:0]  mac;
    logic [15:0] cfg_w;
    logic [15:0] exp_q[$]; // expected read data, oldest first
    int          n_fail = 0;
    int          check_count = 0;
    int          an_cnt = 0;
    int          seed_v;
    assign cfg_w = {5'h00, pa, mac, media, spd, off, adv, fm, hi};
    always #5 sys_clk = ~sys_clk;
    scs_strap_src i_scs_strap_src (.level(lvl), .drive_en(den), .pin(pin));
    scs_sampler i_scs_sampler (
        .sys_clk(sys_clk), .rst_b(rst_b),
        .media_conv_strap(pin[8]), .phy_addr_strap_bit0(pin[0]), .phy_addr_strap_bit1(pin[1]),
        .phy_addr_strap_bit2(pin[2]), .powerdown_after_reset_strap(pin[3]), .master_pref_strap(pin[4]),
        .tx_level_strap(pin[5]), .mac_if_strap_lo(pin[6]), .mac_if_strap_hi(pin[7]),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .pins_released_r(rel), .phy_addr_r(pa), .mac_if_sel_r(mac),
        .media_conv_en_r(media), .soft_powerdown_ctl_r(spd), .adv_master_pref_r(adv),
        .forced_master_cfg_r(fm), .high_tx_level_ability_r(hi), .modules_off_r(off),
        .autoneg_start_r(an));
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input logic [15:0] e, input logic [15:0] a);
        check_count++;
        if (a !== e)
        begin
            n_fail++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // rd_d marks the cycle in which the read data stand
    always @(posedge sys_clk)
    begin
        rd_d <= reg_rd;
    end
    // read monitor: results are looked at mid-cycle, clear of the edge that launches them
    always @(negedge sys_clk)
    begin
        if (rd_d)
            chk(exp_q.pop_front(), reg_rdata_r);
        if (an === 1'b1)
            an_cnt++;
    end
    // ----------------------------------------
    // bus and reset tasks
    // ----------------------------------------
    // strobe is dropped and an edge passes, so back to back calls never collide
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_rel();
        int k;
        k = 0;
        while (rel !== 1'b1 && k < 40)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (rel !== 1'b1)
        begin
            n_fail++;
            conclude();
        end
        repeat (4) @(posedge sys_clk);
    endtask
    // straps are applied together with reset and held through the latch cycle
    task automatic do_reset(input logic [8:0] l, input logic [8:0] e);
        lvl <= l;
        den <= e;
        rst_b <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        an_cnt = 0;
        wait_rel();
    endtask
    function automatic logic [15:0] exp_cfg(input logic [8:0] p);
        return {5'h00, p[2:0], p[7:6], p[8] & (p[7:6] == 2'b00), ~p[3], ~p[3], p[4], p[4], ~p[5]};
    endfunction
    task automatic chk_cfg(input logic [15:0] e);
        #1;
        chk(e, cfg_w);
        @(posedge sys_clk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [8:0] l;
        logic [8:0] p;
        seed_v = $urandom(32277);
        @(posedge sys_clk);
        for (int i = 0; i < 6; i++)
        begin
            l = 9'($urandom);
            if (i < 4)
                l[7:6] = i[1:0]; // every mac code once
            if (i == 5)
                l[5:3] = 3'b100; // tx strap high, power-down strap low
            p = (i == 0) ? 9'h000 : l; // first pass leaves every strap floating
            do_reset(l, (i == 0) ? 9'h000 : 9'h1ff);
            chk_cfg(exp_cfg(p));
            chk(16'(an_cnt), {15'h0000, p[3]});
            rd(`SCS_ADDR_STRAPS, {6'h00, p, 1'b0});
            lvl <= ~l; // later pin activity
            den <= 9'h1ff;
            repeat (3) @(posedge sys_clk);
            chk_cfg(exp_cfg(p));
            $display("strap pass %0d done", i);
        end
        // writes: leave power-down, flip master bits, try to raise a locked ability
        wr(`SCS_ADDR_CTRL, {10'h000, 1'b0, 1'b1, 1'b1, ~p[4], ~p[4], 1'b0});
        repeat (2) @(posedge sys_clk);
        chk_cfg(exp_cfg(p) ^ 16'h001e);
        rd(`SCS_ADDR_CTRL, {10'h000, 1'b0, 1'b1, 1'b0, ~p[4], ~p[4], 1'b0});
        rd(`SCS_ADDR_STATUS, 16'h0003);
        rd(4'hf, 16'h0000);
        $display("write pass done");
        // software reset reloads defaults from fresh strap levels
        l = 9'($urandom);
        lvl <= l;
        wr(`SCS_ADDR_CTRL, 16'h0030);
        an_cnt = 0;
        repeat (12) @(posedge sys_clk);
        chk_cfg(exp_cfg(l));
        chk(16'(an_cnt), {15'h0000, l[3]});
        $display("soft reset pass done");
        // autoneg disabled: a reset event with power-down off must not start it
        l = l | 9'h008;
        lvl <= l;
        wr(`SCS_ADDR_CTRL, 16'h0020);
        an_cnt = 0;
        repeat (12) @(posedge sys_clk);
        chk_cfg(exp_cfg(l));
        chk(16'(an_cnt), 16'h0000);
        $display("autoneg off pass done");
        conclude();
    end
endmodule
